// ==== i2cim_defines.svh ====
`ifndef I2CIM_DEFINES_SVH
`define I2CIM_DEFINES_SVH

// register byte offsets on the apb bus
`define I2CIM_OFF_ENABLE 8'h04
`define I2CIM_OFF_STATUS 8'h08
`define I2CIM_OFF_CLEAR 8'h40

// register widths
`define I2CIM_EN_W 7
`define I2CIM_ST_W 15

// status field positions
`define I2CIM_ST_SLAVE_DIRECTION 14
`define I2CIM_ST_NO_ACK_SENT 13
`define I2CIM_ST_BUSY 12
`define I2CIM_ST_RECEIVE_SHIFT_FULL 11
`define I2CIM_ST_TRANSMIT_SHIFT_EMPTY 10
`define I2CIM_ST_AAS 9
`define I2CIM_ST_GCALL 8
`define I2CIM_ST_SCD 5
`define I2CIM_ST_XRDY 4
`define I2CIM_ST_RRDY 3
`define I2CIM_ST_REGISTERS_READY 2
`define I2CIM_ST_NACK 1
`define I2CIM_ST_AL 0

// enable field position of the addressed-as-slave source
`define I2CIM_EN_AAS 6

// reset values and write masks
`define I2CIM_EN_RST 7'h00
`define I2CIM_ST_RST 15'h0410
`define I2CIM_ST_W1C 15'h703F

// synchroniser depth for pins
`define I2CIM_SYNC_STAGES 2

`endif

// ==== i2cim_pkg.sv ====
package i2cim_pkg;

  // one-cycle event pulses from the serial engine
  typedef struct packed {
    logic arb_lost;
    logic illegal_cond;
    logic nack_rcvd;
    logic regs_ready;
    logic rx_ready;
    logic tx_ready;
    logic own_addr_match;
    logic zero_addr_match;
    logic nack_sent;
    logic slave_tx_begin;
  } i2cim_evt_t;

  // steady levels from the serial engine and mode control
  typedef struct packed {
    logic rx_shift_full;
    logic tx_shift_empty;
    logic slave_tx;
    logic internal_loopback;
  } i2cim_lvl_t;

  // apb request side
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } i2cim_apb_t;

  // bus conditions seen on the pins
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
  } i2cim_cond_t;

endpackage

// ==== i2cim_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2cim_defines.svh"

module i2cim_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] d,
  output logic [1:0] q
);

  logic [1:0] meta_r;

  // first stage feeds only the second; pins idle high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 2'h3;
      q <= 2'h3;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ==== i2cim_link_mon.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2cim_defines.svh"

module i2cim_link_mon (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_s,
  input wire logic sda_s,
  output i2cim_pkg::i2cim_cond_t cond
);

  logic scl_d_r;
  logic sda_d_r;
  logic sda_fall;
  logic sda_rise;
  logic scl_hold;

  // one more stage of history to find data edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // data moving while clock stays high marks start or stop
  assign scl_hold = scl_s & scl_d_r;
  assign sda_fall = sda_d_r & ~sda_s;
  assign sda_rise = ~sda_d_r & sda_s;
  assign cond.start_seen = scl_hold & sda_fall;
  assign cond.stop_seen = scl_hold & sda_rise;

endmodule

`default_nettype wire

// ==== i2cim_regs.sv ====
// How it works
// - seven enables: 6 aas, 5 scd, 4 xrdy, 3 rrdy, 2 registers_ready, 1 nack, 0 al
// - upper bits of both registers read zero and ignore writes
// - status holds direction, nack-sent, busy, shift, address bits, six flags
// - writing one clears a clearable status bit, writing zero keeps it
// - after reset transmit-shift-empty and transmit-ready read one
// - slave direction stays zero during internal loopback
// - slave direction reads one only while acting as slave transmitter
// - slave direction clears on start, stop, or a written one
// - arbitration-lost flag rises on lost arbitration or illegal condition
// - no-acknowledge flag rises when master gets no acknowledge
// - addressed-as-slave rises on own address or all-zero address
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2cim_defines.svh"

module i2cim_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire i2cim_pkg::i2cim_apb_t apb,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  input wire i2cim_pkg::i2cim_evt_t evt,
  input wire i2cim_pkg::i2cim_lvl_t lvl,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic irq_r,
  output logic bus_busy_r
);

  // sticky update: a set in the same cycle beats any clear
  function automatic logic flag_nxt(
    input logic cur,
    input logic set,
    input logic clr
  );
    flag_nxt = set | (cur & ~clr);
  endfunction

  // address compare used by read and write decode
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    hit = (addr == off);
  endfunction

  logic [1:0] pins_s;
  i2cim_pkg::i2cim_cond_t cond;
  logic [`I2CIM_EN_W-1:0] enable_r;
  logic [`I2CIM_EN_W-1:0] enable_nxt;
  logic [`I2CIM_ST_W-1:0] stat_r;
  logic [`I2CIM_ST_W-1:0] stat_nxt;
  logic [`I2CIM_ST_W-1:0] clr_vec;
  logic [`I2CIM_ST_W-1:0] set_vec;
  logic [31:0] rdata_nxt;
  logic access;
  logic commit;
  logic wr_commit;
  logic hit_en;
  logic hit_st;
  logic hit_clr;
  logic mapped;
  logic bus_edge;
  logic slave_direction_set;
  logic addr_hit;
  logic irq_nxt;
  logic first_r;

  // pins come from the bus side and are synchronised first
  i2cim_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({scl_pin, sda_pin}),
    .q(pins_s)
  );

  i2cim_link_mon u_mon (
    .clk(clk),
    .rst_b(rst_b),
    .scl_s(pins_s[1]),
    .sda_s(pins_s[0]),
    .cond(cond)
  );

  // apb decode: the access phase completes on the edge with pready high
  assign access = apb.psel & apb.penable;
  assign commit = access & pready_r;
  assign wr_commit = commit & apb.pwrite;
  assign hit_en = hit(apb.paddr, `I2CIM_OFF_ENABLE);
  assign hit_st = hit(apb.paddr, `I2CIM_OFF_STATUS);
  assign hit_clr = hit(apb.paddr, `I2CIM_OFF_CLEAR);
  assign mapped = hit_en | hit_st | hit_clr;

  // enable register keeps only its seven low bits
  // enable bit storage
  assign enable_nxt = (wr_commit && hit_en) ?
                      apb.pwdata[`I2CIM_EN_W-1:0] : enable_r;

  // clears come from status writes and the write-only clear register
  // write one clears
  assign clr_vec = (wr_commit && (hit_st || hit_clr)) ?
                   (apb.pwdata[`I2CIM_ST_W-1:0] & `I2CIM_ST_W1C) :
                   {`I2CIM_ST_W{1'b0}};

  assign bus_edge = cond.start_seen | cond.stop_seen;
  assign addr_hit = evt.own_addr_match | evt.zero_addr_match;
  assign slave_direction_set = evt.slave_tx_begin & lvl.slave_tx;

  // hardware set terms, bit for bit with the status layout
  assign set_vec[`I2CIM_ST_SLAVE_DIRECTION] = slave_direction_set;
  assign set_vec[`I2CIM_ST_NO_ACK_SENT] = evt.nack_sent;
  assign set_vec[`I2CIM_ST_BUSY] = cond.start_seen;
  assign set_vec[`I2CIM_ST_RECEIVE_SHIFT_FULL] = 1'b0;
  assign set_vec[`I2CIM_ST_TRANSMIT_SHIFT_EMPTY] = 1'b0;
  assign set_vec[`I2CIM_ST_AAS] = addr_hit;
  assign set_vec[`I2CIM_ST_GCALL] = evt.zero_addr_match;
  assign set_vec[7:6] = 2'h0;
  assign set_vec[`I2CIM_ST_SCD] = cond.stop_seen;
  assign set_vec[`I2CIM_ST_XRDY] = evt.tx_ready;
  assign set_vec[`I2CIM_ST_RRDY] = evt.rx_ready;
  assign set_vec[`I2CIM_ST_REGISTERS_READY] = evt.regs_ready;
  assign set_vec[`I2CIM_ST_NACK] = evt.nack_rcvd;
  assign set_vec[`I2CIM_ST_AL] = evt.arb_lost | evt.illegal_cond;

  // direction bit: loopback forces zero, bus conditions clear it
  assign stat_nxt[`I2CIM_ST_SLAVE_DIRECTION] = ~lvl.internal_loopback &
    flag_nxt(stat_r[`I2CIM_ST_SLAVE_DIRECTION], set_vec[`I2CIM_ST_SLAVE_DIRECTION],
             clr_vec[`I2CIM_ST_SLAVE_DIRECTION] | bus_edge);
  assign stat_nxt[`I2CIM_ST_NO_ACK_SENT] =
    flag_nxt(stat_r[`I2CIM_ST_NO_ACK_SENT], set_vec[`I2CIM_ST_NO_ACK_SENT],
             clr_vec[`I2CIM_ST_NO_ACK_SENT]);
  // busy drops on a stop or a written one
  assign stat_nxt[`I2CIM_ST_BUSY] =
    flag_nxt(stat_r[`I2CIM_ST_BUSY], set_vec[`I2CIM_ST_BUSY],
             clr_vec[`I2CIM_ST_BUSY] | cond.stop_seen);

  // read-only shift indicators follow the engine levels
  assign stat_nxt[`I2CIM_ST_RECEIVE_SHIFT_FULL] = lvl.rx_shift_full;
  assign stat_nxt[`I2CIM_ST_TRANSMIT_SHIFT_EMPTY] = lvl.tx_shift_empty;

  // address bits hold until a stop; the general call bit also clears on an own-address match
  assign stat_nxt[`I2CIM_ST_AAS] =
    flag_nxt(stat_r[`I2CIM_ST_AAS], set_vec[`I2CIM_ST_AAS],
             cond.stop_seen);
  assign stat_nxt[`I2CIM_ST_GCALL] =
    flag_nxt(stat_r[`I2CIM_ST_GCALL], set_vec[`I2CIM_ST_GCALL],
             cond.stop_seen | evt.own_addr_match);
  assign stat_nxt[7:6] = 2'h0; // reserved, always zero

  // six event flags share one sticky form
  assign stat_nxt[5:0] = set_vec[5:0] | (stat_r[5:0] & ~clr_vec[5:0]);

  // enabled flags gate onto one level interrupt
  assign irq_nxt = |(enable_r[5:0] & stat_r[5:0]) |
                   (enable_r[`I2CIM_EN_AAS] & stat_r[`I2CIM_ST_AAS]);

  // read mux; the clear register and unused bits read zero
  // upper bits read zero
  assign rdata_nxt = hit_en ? {25'h0000000, enable_r} :
                     hit_st ? {17'h00000, stat_r} : 32'h00000000;

  // register file state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_r <= `I2CIM_EN_RST;
      stat_r <= `I2CIM_ST_RST;
    end else begin
      enable_r <= enable_nxt;
      stat_r <= stat_nxt;
    end
  end

  // one wait state: pready comes from a flop so reads see settled data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access && !pready_r && !apb.pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // interrupt and busy outputs, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      bus_busy_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      bus_busy_r <= stat_nxt[`I2CIM_ST_BUSY];
    end
  end

  // marks the first cycle after release, for checking reset values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // checks kept next to the logic they watch

  reset_values_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    first_r |-> (stat_r == `I2CIM_ST_RST) && (enable_r == `I2CIM_EN_RST))
    else $error("status or enable not at reset value");

  enable_upper_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_commit && hit_en) |=>
      enable_r == $past(apb.pwdata[`I2CIM_EN_W-1:0]))
    else $error("enable write not stored in low seven bits");

  rsvd_zero_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (access && !pready_r && !apb.pwrite && (hit_en || hit_st)) |=>
      pready_r && (prdata_r[31:15] == 17'h00000) &&
      ($past(hit_en) -> prdata_r[14:7] == 8'h00))
    else $error("reserved bits read nonzero");

  status_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (access && !pready_r && !apb.pwrite && hit_st) |=>
      prdata_r[14:0] == $past(stat_r))
    else $error("status read does not match layout");

  w1c_clear_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_commit && hit_st && apb.pwdata[`I2CIM_ST_REGISTERS_READY] &&
     !evt.regs_ready) |=> !stat_r[`I2CIM_ST_REGISTERS_READY])
    else $error("written one did not clear flag");

  w1c_keep_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_commit && hit_st && !apb.pwdata[`I2CIM_ST_SCD] &&
     stat_r[`I2CIM_ST_SCD]) |=> stat_r[`I2CIM_ST_SCD])
    else $error("written zero changed flag");

  loopback_slave_direction_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    lvl.internal_loopback |=> !stat_r[`I2CIM_ST_SLAVE_DIRECTION])
    else $error("slave direction set during loopback");

  slave_direction_set_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (evt.slave_tx_begin && lvl.slave_tx && !lvl.internal_loopback)
      |=> stat_r[`I2CIM_ST_SLAVE_DIRECTION] && irq_nxt == $past(irq_nxt) ||
          stat_r[`I2CIM_ST_SLAVE_DIRECTION])
    else $error("slave direction not set as slave transmitter");

  slave_direction_clear_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (bus_edge && !slave_direction_set) |=> !stat_r[`I2CIM_ST_SLAVE_DIRECTION])
    else $error("slave direction kept over start or stop");

  arb_lost_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (evt.arb_lost || evt.illegal_cond) |=> stat_r[`I2CIM_ST_AL])
    else $error("arbitration lost flag not raised");

  nack_flag_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    evt.nack_rcvd |=> stat_r[`I2CIM_ST_NACK])
    else $error("no acknowledge flag not raised");

  addr_slave_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (evt.own_addr_match || evt.zero_addr_match) |=>
      stat_r[`I2CIM_ST_AAS])
    else $error("addressed as slave not raised");

  irq_level_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    ((|(enable_r[5:0] & stat_r[5:0])) [*2]) |-> irq_r)
    else $error("interrupt low with enabled flag set");

  irq_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (enable_r == `I2CIM_EN_RST) [*2] |-> !irq_r)
    else $error("interrupt high with all sources disabled");

  busy_set_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    cond.start_seen |=> stat_r[`I2CIM_ST_BUSY])
    else $error("bus busy not set by start");

  busy_stop_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (cond.stop_seen && !cond.start_seen) |=> !stat_r[`I2CIM_ST_BUSY])
    else $error("bus busy kept over stop");

  shift_follow_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> stat_r[11:10] ==
      $past({lvl.rx_shift_full, lvl.tx_shift_empty}))
    else $error("shift indicators do not follow engine");

  stop_flag_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    cond.stop_seen |=> stat_r[`I2CIM_ST_SCD])
    else $error("stop detected flag not raised");

  gcall_flag_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    evt.zero_addr_match |=> stat_r[`I2CIM_ST_GCALL])
    else $error("general call bit not raised");

  irq_slave_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (enable_r[`I2CIM_EN_AAS] && stat_r[`I2CIM_ST_AAS]) [*2] |-> irq_r)
    else $error("interrupt low with addressed source enabled");

  unmapped_err_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (access && !pready_r && !mapped) |=> pready_r && pslverr_r)
    else $error("unmapped access not flagged");

  enable_keep_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(wr_commit && hit_en) |=> $stable(enable_r))
    else $error("enable changed without a write");

endmodule

`default_nettype wire

// ==== i2cim_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// far-side bus party; lines are driven high when idle,
// so the link clock stands still between frames
module i2cim_bus_model (
  output var logic scl,
  output var logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // (repeated) start: data falls while clock is high, steps 100 ns apart
  task automatic gen_start();
    sda = 1'b1;
    #100;
    scl = 1'b1;
    #100;
    sda = 1'b0;
    #100;
    scl = 1'b0;
    #100;
  endtask

  // stop: data rises while clock is high, then the bus is left idle
  task automatic gen_stop();
    sda = 1'b0;
    #100;
    scl = 1'b1;
    #100;
    sda = 1'b1;
    #100;
  endtask
endmodule

`default_nettype wire

// ==== i2cim_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2cim_defines.svh"

module testbench;
  logic clk;
  logic rst_b;
  i2cim_pkg::i2cim_apb_t apb;
  i2cim_pkg::i2cim_evt_t evt;
  i2cim_pkg::i2cim_lvl_t lvl;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic bus_busy_r;
  wire logic scl;
  wire logic sda;
  int err_total;
  int checks;
  logic [31:0] rd;
  logic er;

  i2cim_regs uut (.clk(clk), .rst_b(rst_b), .apb(apb),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .evt(evt), .lvl(lvl), .scl_pin(scl), .sda_pin(sda),
    .irq_r(irq_r), .bus_busy_r(bus_busy_r));
  i2cim_bus_model bus (.scl(scl), .sda(sda));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    n = 0;
    // look between edges so the flop outputs have settled
    do begin
      @(negedge clk);
      n++;
    end while (pready_r !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    rd = prdata_r;
    er = pslverr_r;
    @(posedge clk);
    apb <= '0;
    @(negedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // one-cycle event pulse from the serial engine
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= '0;
  endtask

  task automatic t_reset();
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_0410);
    rdchk(`I2CIM_OFF_ENABLE, 32'h0000_0000);
    xfer(1'b1, `I2CIM_OFF_ENABLE, 32'hFFFF_FFFF);
    rdchk(`I2CIM_OFF_ENABLE, 32'h0000_007F);
    xfer(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    xfer(1'b1, `I2CIM_OFF_ENABLE, 32'h0);
    xfer(1'b1, `I2CIM_OFF_STATUS, 32'h0000_0010);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_0400);
  endtask

  // each event flag but stop-detected: set while masked, gated onto irq, cleared by one
  task automatic t_flags();
    logic [9:0] ev[6] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020,
      10'h010};
    int sb[6] = '{0, 0, 1, 2, 3, 4};
    logic [31:0] m;
    for (int i = 0; i < 6; i++) begin
      m = 32'h1 << sb[i];
      pulse(ev[i]);
      rdchk(`I2CIM_OFF_STATUS, 32'h400 | m);
      chk({31'h0, irq_r}, 32'h0);
      xfer(1'b1, `I2CIM_OFF_STATUS, 32'h0);
      rdchk(`I2CIM_OFF_STATUS, 32'h400 | m);
      xfer(1'b1, `I2CIM_OFF_ENABLE, m);
      repeat (2) @(negedge clk);
      chk({31'h0, irq_r}, 32'h1);
      xfer(1'b1, `I2CIM_OFF_STATUS, 32'hFFFF_FFFF);
      rdchk(`I2CIM_OFF_STATUS, 32'h0000_0400);
      chk({31'h0, irq_r}, 32'h0);
      xfer(1'b1, `I2CIM_OFF_ENABLE, 32'h0);
    end
  endtask

  // addressing, direction, busy and stop through the pins
  task automatic t_slave();
    pulse(10'h008);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_0600);
    xfer(1'b1, `I2CIM_OFF_ENABLE, 32'h40);
    repeat (2) @(negedge clk);
    chk({31'h0, irq_r}, 32'h1);
    xfer(1'b1, `I2CIM_OFF_ENABLE, 32'h0);
    pulse(10'h004);
    bus.gen_start();
    repeat (6) @(posedge clk);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1700);
    chk({31'h0, bus_busy_r}, 32'h1);
    lvl.slave_tx <= 1'b1;
    pulse(10'h001);
    pulse(10'h002);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_7700);
    xfer(1'b1, `I2CIM_OFF_STATUS, 32'h0000_2000);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_5700);
    bus.gen_start();
    repeat (6) @(posedge clk);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1700);
    pulse(10'h001);
    xfer(1'b1, `I2CIM_OFF_STATUS, 32'h0000_4000);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1700);
    lvl.internal_loopback <= 1'b1;
    pulse(10'h001);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1700);
    lvl <= 4'b1100;
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1F00);
    xfer(1'b1, `I2CIM_OFF_STATUS, 32'h0000_0F00);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_1F00);
    lvl <= 4'b0000;
    bus.gen_stop();
    repeat (6) @(posedge clk);
    rdchk(`I2CIM_OFF_STATUS, 32'h0000_0020);
    chk({31'h0, bus_busy_r}, 32'h0);
  endtask

  // reset for three cycles, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    apb = '0;
    evt = '0;
    lvl = 4'b0100;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_flags();
    t_slave();
    end_sim();
  end
endmodule

`default_nettype wire
